// *** rtl/synth_control_latches.sv ***
// control word latches, power-down and fastlock control of the synthesizer
// How it works
// - host shifts 24 bits msb first on clock rises; strobe rise moves word
// - two low bits pick the latch: 00 ref, 01 feedback, 10 func, 11 init
// - control pair 10 writes the function latch
// - counter hold bit set keeps both divider counters in reset
// - reset leaves counter hold clear, so counters run normally after power-up
// - two power-down bits act only while chip enable allows
// - chip enable low powers down at once, whatever the bits say
// - lower bit set with upper bit clear powers down immediately
// - both bits set waits for the next charge pump event
// - any power-down forces counters to load state
// - any power-down puts the charge pump in high impedance
// - any power-down clears lock detection
// - power-down removes dc paths, debiases rf input, stops ref buffer
// - serial register keeps loading words while powered down
// - three-bit select routes an internal signal to the observe pin
// - fastlock only while function bit 9 is set
// - function bit 10 picks fastlock mode one or two
// - mode one: fast request set selects the second current setting
// - mode one: fast request cleared returns to the first setting
// - init write pulses counter reset; first feedback write pulses again
`timescale 1ns/10ps
`include "synth_consts.svh"
module synth_control_latches #(
  parameter int OBS_N = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // serial port pins
  input  wire logic             serial_clock,
  input  wire logic             serial_data,
  input  wire logic             latch_strobe,
  // power and pump pins
  input  wire logic             chip_enable,
  input  wire logic             pump_event,
  // internal signals offered to the observe pin
  input  wire logic [OBS_N-1:0] observe_sources,
  // reference divider fields
  output logic      [13:0]      ref_ratio,
  output logic                  lock_window_count_sel,
  output logic      [1:0]       test_sel,
  output logic      [1:0]       pulse_width_sel,
  // feedback divider fields
  output logic      [12:0]      main_count,
  output logic      [5:0]       swallow_count,
  // function fields
  output logic      [1:0]       prescale_sel,
  output logic      [3:0]       fast_timeout,
  output logic                  detector_sign,
  output logic      [2:0]       pump_current,
  output logic                  fast_lock_active,
  // counter and power control
  output logic                  counter_load,
  output logic                  pump_hiz_out,
  output logic                  lock_detect_clear,
  output logic                  dc_paths_off,
  output logic                  rf_debias,
  output logic                  ref_buffer_off,
  output logic                  powered_down,
  // observation
  output logic                  observe_output
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] pins_s;

  sync_two #(
    .W (5)
  ) u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({pump_event, chip_enable, latch_strobe, serial_data, serial_clock}),
    .sync_out (pins_s)
  );

  wire ce_s   = pins_s[3];
  wire pump_s = pins_s[4];

  // ---------------------------------------------------------------
  // serial input register
  // ---------------------------------------------------------------
  synth_pkg::word_type word;
  logic                load;

  serial_shift #(
    .W (`WORD_W)
  ) u_shift (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .sclk_s   (pins_s[0]),
    .sdata_s  (pins_s[1]),
    .strobe_s (pins_s[2]),
    .word_reg (word),
    .load_reg (load)
  );

  // ---------------------------------------------------------------
  // destination decode
  // ---------------------------------------------------------------
  wire [1:0] dest    = {word[`DEST_HI], word[`DEST_LO]};
  wire       wr_ref  = load & (dest == `DEST_REF);
  wire       wr_fb   = load & (dest == `DEST_FB);
  wire       wr_init = load & (dest == `DEST_INIT);
  wire       wr_func = load & ((dest == `DEST_FUNC) | wr_init);

  // ---------------------------------------------------------------
  // latches
  // ---------------------------------------------------------------
  synth_pkg::word_type ref_word_reg;
  synth_pkg::word_type fb_word_reg;
  synth_pkg::word_type func_word_reg;
  logic                arm_reg;
  logic                reset_pulse_reg;

  // init arms one more pulse for the next feedback write only
  wire reset_pulse_next = wr_init | (wr_fb & arm_reg);
  wire arm_next         = wr_init | (arm_reg & ~wr_fb);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ref_word_reg    <= `WORD_RST;
      fb_word_reg     <= `WORD_RST;
      func_word_reg   <= `WORD_RST;
      arm_reg         <= 1'h0;
      reset_pulse_reg <= 1'h0;
    end else begin
      arm_reg         <= arm_next;
      reset_pulse_reg <= reset_pulse_next;
      if (wr_ref) begin
        ref_word_reg <= word;
      end
      if (wr_fb) begin
        fb_word_reg <= word;
      end
      if (wr_func) begin
        func_word_reg <= word;
      end
    end
  end

  // ---------------------------------------------------------------
  // field outputs
  // ---------------------------------------------------------------
  assign ref_ratio             = ref_word_reg[`REF_RATIO_HI:`REF_RATIO_LO];
  assign lock_window_count_sel = ref_word_reg[`REF_LDP];
  assign test_sel              = ref_word_reg[`REF_TEST_HI:`REF_TEST_LO];
  assign pulse_width_sel       = ref_word_reg[`REF_PW_HI:`REF_PW_LO];
  assign main_count            = fb_word_reg[`FB_MAIN_HI:`FB_MAIN_LO];
  assign swallow_count         = fb_word_reg[`FB_SWAL_HI:`FB_SWAL_LO];
  assign prescale_sel          = func_word_reg[`FN_PRE_HI:`FN_PRE_LO];
  assign fast_timeout          = func_word_reg[`FN_TMO_HI:`FN_TMO_LO];
  assign detector_sign         = func_word_reg[`FN_SIGN];

  wire       pd1       = func_word_reg[`FN_PD1];
  wire       pd2       = func_word_reg[`FN_PD2];
  wire       hold      = func_word_reg[`FN_HOLD];
  wire [2:0] obs_sel   = func_word_reg[`FN_OBS_HI:`FN_OBS_LO];
  wire [2:0] boost_cur = func_word_reg[`FN_BOOST_HI:`FN_BOOST_LO];
  wire [2:0] norm_cur  = func_word_reg[`FN_NORM_HI:`FN_NORM_LO];

  // ---------------------------------------------------------------
  // power-down control
  // ---------------------------------------------------------------
  synth_pkg::pd_state_type pd_state_reg;
  synth_pkg::pd_state_type pd_state_next;
  logic                    pump_prev_reg;

  wire pump_rise = pump_s & ~pump_prev_reg;
  wire async_pd  = pd1 & ~pd2;
  wire sync_req  = pd1 & pd2;

  always_comb begin
    pd_state_next = pd_state_reg;
    case (pd_state_reg)
      synth_pkg::pd_run: begin
        if (async_pd) begin
          pd_state_next = synth_pkg::pd_down;
        end else if (sync_req) begin
          pd_state_next = synth_pkg::pd_armed;
        end
      end
      synth_pkg::pd_armed: begin
        if (async_pd) begin
          pd_state_next = synth_pkg::pd_down;
        end else if (!sync_req) begin
          pd_state_next = synth_pkg::pd_run;
        end else if (pump_rise) begin
          pd_state_next = synth_pkg::pd_down;
        end
      end
      synth_pkg::pd_down: begin
        if (!pd1) begin
          pd_state_next = synth_pkg::pd_run;
        end
      end
      default: begin
        pd_state_next = synth_pkg::pd_run;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pd_state_reg  <= synth_pkg::pd_run;
      pump_prev_reg <= 1'h0;
    end else begin
      pd_state_reg  <= pd_state_next;
      pump_prev_reg <= pump_s;
    end
  end

  // the bits only count while chip enable is high; low pin overrides all
  wire pd_any = ~ce_s | (pd_state_reg == synth_pkg::pd_down);

  // ---------------------------------------------------------------
  // counter, pump and bias controls
  // ---------------------------------------------------------------
  // hold keeps counters at load point but is not a power-down
  wire load_next = pd_any | hold | reset_pulse_reg;
  wire hiz_next  = load_next | func_word_reg[`FN_HIZ];

  // ---------------------------------------------------------------
  // fastlock
  // ---------------------------------------------------------------
  // mode two timer lives with the analog counters; here it keeps setting 1
  wire fast_mode_one = func_word_reg[`FN_FMODE] == `FAST_MODE_ONE;
  wire fast_next     = func_word_reg[`FN_FEN] & fast_mode_one
                     & fb_word_reg[`FB_FAST_REQ];
  wire [2:0] cur_next = fast_next ? boost_cur : norm_cur;

  // ---------------------------------------------------------------
  // output flops
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      counter_load      <= 1'h1;
      pump_hiz_out      <= 1'h1;
      lock_detect_clear <= 1'h1;
      dc_paths_off      <= 1'h1;
      rf_debias         <= 1'h1;
      ref_buffer_off    <= 1'h1;
      powered_down      <= 1'h1;
      fast_lock_active  <= 1'h0;
      pump_current      <= 3'h0;
      observe_output    <= 1'h0;
    end else begin
      counter_load      <= load_next;
      pump_hiz_out      <= hiz_next;
      lock_detect_clear <= pd_any;
      dc_paths_off      <= pd_any;
      rf_debias         <= pd_any;
      ref_buffer_off    <= pd_any;
      powered_down      <= pd_any;
      fast_lock_active  <= fast_next;
      pump_current      <= cur_next;
      observe_output    <= observe_sources[obs_sel];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_init_write;
    load && (dest == `DEST_INIT);
  endsequence

  sequence s_pulse_then_load;
    reset_pulse_reg ##1 counter_load;
  endsequence

  property p_func_write;
    load && (dest == `DEST_FUNC) |=> func_word_reg == $past(word);
  endproperty
  a_func_write: assert property (p_func_write) else $error("function word not latched");

  property p_ref_write;
    load && (dest == `DEST_REF) |=> ref_word_reg == $past(word) && fb_word_reg == $past(fb_word_reg);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference word misrouted");

  property p_hold;
    hold |=> counter_load && pump_hiz_out;
  endproperty
  a_hold: assert property (p_hold) else $error("counters not held");

  property p_ce_low;
    !ce_s |=> powered_down && pump_hiz_out && counter_load;
  endproperty
  a_ce_low: assert property (p_ce_low) else $error("chip enable low ignored");

  property p_async_pd;
    ce_s && async_pd && pd_state_reg == synth_pkg::pd_run |=> ##1 powered_down;
  endproperty
  a_async_pd: assert property (p_async_pd) else $error("immediate power-down late");

  property p_sync_wait;
    ce_s && sync_req && !pump_rise && pd_state_reg == synth_pkg::pd_armed |=> ##1 !powered_down;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("power-down before pump event");

  property p_pd_effects;
    pd_any |=> lock_detect_clear && dc_paths_off && rf_debias && ref_buffer_off;
  endproperty
  a_pd_effects: assert property (p_pd_effects) else $error("power-down effects missing");

  property p_fast_on;
    fast_next |=> fast_lock_active && pump_current == $past(boost_cur);
  endproperty
  a_fast_on: assert property (p_fast_on) else $error("boost current not selected");

  property p_fast_off;
    !fb_word_reg[`FB_FAST_REQ] |=> !fast_lock_active && pump_current == $past(norm_cur);
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("normal current not restored");

  property p_init_pulse;
    s_init_write |=> s_pulse_then_load;
  endproperty
  a_init_pulse: assert property (p_init_pulse) else $error("init reset pulse missing");

  property p_fb_pulse;
    load && (dest == `DEST_FB) && arm_reg |=> reset_pulse_reg && !arm_reg;
  endproperty
  a_fb_pulse: assert property (p_fb_pulse) else $error("feedback reset pulse missing");

  property p_down_write;
    powered_down && load && (dest == `DEST_REF) |=> ref_word_reg == $past(word);
  endproperty
  a_down_write: assert property (p_down_write) else $error("word lost while powered down");

  property p_pd_hiz;
    pd_any |=> counter_load && pump_hiz_out;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("power-down left pump or counters free");

  property p_fast_en;
    !func_word_reg[`FN_FEN] |=> !fast_lock_active;
  endproperty
  a_fast_en: assert property (p_fast_en) else $error("fastlock active while disabled");

endmodule : synth_control_latches

// *** shared/synth_consts.svh ***
// field positions, destination codes and reset values of the control words
`ifndef SYNTH_CONSTS_SVH
`define SYNTH_CONSTS_SVH

// ---------------------------------------------------------------
// word and destination codes
// ---------------------------------------------------------------
`define WORD_W        24
`define WORD_RST      24'h000000
`define DEST_HI       1
`define DEST_LO       0
`define DEST_REF      2'h0
`define DEST_FB       2'h1
`define DEST_FUNC     2'h2
`define DEST_INIT     2'h3

// ---------------------------------------------------------------
// reference divider word
// ---------------------------------------------------------------
`define REF_LDP       20
`define REF_TEST_HI   19
`define REF_TEST_LO   18
`define REF_PW_HI     17
`define REF_PW_LO     16
`define REF_RATIO_HI  15
`define REF_RATIO_LO  2

// ---------------------------------------------------------------
// feedback divider word
// ---------------------------------------------------------------
`define FB_FAST_REQ   21
`define FB_MAIN_HI    20
`define FB_MAIN_LO    8
`define FB_SWAL_HI    7
`define FB_SWAL_LO    2

// ---------------------------------------------------------------
// function and initialization word
// ---------------------------------------------------------------
`define FN_PRE_HI     23
`define FN_PRE_LO     22
`define FN_PD2        21
`define FN_BOOST_HI   20
`define FN_BOOST_LO   18
`define FN_NORM_HI    17
`define FN_NORM_LO    15
`define FN_TMO_HI     14
`define FN_TMO_LO     11
`define FN_FMODE      10
`define FN_FEN        9
`define FN_HIZ        8
`define FN_SIGN       7
`define FN_OBS_HI     6
`define FN_OBS_LO     4
`define FN_PD1        3
`define FN_HOLD       2
`define FAST_MODE_ONE 1'h0

`endif

// *** shared/synth_pkg.sv ***
// types shared by the synthesizer control logic
package synth_pkg;
  typedef logic [23:0] word_type;
  typedef enum logic [1:0] {pd_run, pd_armed, pd_down} pd_state_type;
endpackage : synth_pkg

// *** rtl/sync_two.sv ***
// two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
module sync_two #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : sync_two

// *** rtl/serial_shift.sv ***
// serial input register: shifts on clock edges, hands the word on strobe edges
`timescale 1ns/10ps
`include "synth_consts.svh"
module serial_shift #(
  parameter int W = `WORD_W
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // synchronised pins
  input  wire logic         sclk_s,
  input  wire logic         sdata_s,
  input  wire logic         strobe_s,
  // word out
  output logic      [W-1:0] word_reg,
  output logic              load_reg
);
  logic         sclk_prev_reg;
  logic         strobe_prev_reg;
  logic [W-1:0] shift_reg;
  wire          sclk_rise   = sclk_s & ~sclk_prev_reg;
  wire          strobe_rise = strobe_s & ~strobe_prev_reg;
  wire  [W-1:0] shift_next  = {shift_reg[W-2:0], sdata_s};

  // never gated by power-down, so words keep arriving while asleep
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev_reg   <= 1'h0;
      strobe_prev_reg <= 1'h0;
      shift_reg       <= '0;
      word_reg        <= '0;
      load_reg        <= 1'h0;
    end else begin
      sclk_prev_reg   <= sclk_s;
      strobe_prev_reg <= strobe_s;
      load_reg        <= strobe_rise;
      if (sclk_rise) begin
        shift_reg <= shift_next;
      end
      if (strobe_rise) begin
        word_reg <= shift_reg;
      end
    end
  end
endmodule : serial_shift

// *** test/host_serial_model.sv ***
// host side model driving the three-wire serial write port
`timescale 1ns/10ps
module host_serial_model #(
  parameter int HALF = 20
) (
  // clock
  input  wire logic mclk,
  // serial port pins
  output logic      serial_clock,
  output logic      serial_data,
  output logic      latch_strobe
);
  initial begin
    serial_clock = 1'h0;
    serial_data  = 1'h0;
    latch_strobe = 1'h0;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge mclk);
    #1;
  endtask : wait_half

  // clock stands low between frames; pins only move just after an mclk edge
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      wait_half();
      serial_clock = 1'h1;
      wait_half();
      serial_clock = 1'h0;
    end
    // released data line shows no stale bit
    serial_data = ~serial_data;
    wait_half();
    latch_strobe = 1'h1;
    wait_half();
    latch_strobe = 1'h0;
  endtask : send_word
endmodule : host_serial_model

// *** test/test_synth_control_latches.sv ***
// self-checking bench for the control word latches
`timescale 1ns/10ps
`include "synth_consts.svh"
module test_synth_control_latches;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                  mclk, reset_n, chip_enable, pump_event;
  logic                  serial_clock, serial_data, latch_strobe;
  logic [7:0]            observe_sources;
  logic [13:0]           ref_ratio;
  logic [12:0]           main_count;
  logic [5:0]            swallow_count;
  logic [3:0]            fast_timeout;
  logic [2:0]            pump_current;
  logic [1:0]            test_sel, pulse_width_sel, prescale_sel;
  logic                  lock_window_count_sel, detector_sign, fast_lock_active, counter_load, pump_hiz_out;
  logic                  lock_detect_clear, dc_paths_off, rf_debias, ref_buffer_off, powered_down, observe_output;
  synth_pkg::word_type   sh_ref, sh_fb, sh_fn, w;
  int                    n_mismatch, comparisons, n_rise, n0, cycles, seed;
  logic                  cl_q;

  synth_control_latches i_synth_control_latches (
    .mclk(mclk), .reset_n(reset_n), .serial_clock(serial_clock), .serial_data(serial_data),
    .latch_strobe(latch_strobe), .chip_enable(chip_enable), .pump_event(pump_event),
    .observe_sources(observe_sources), .ref_ratio(ref_ratio), .lock_window_count_sel(lock_window_count_sel),
    .test_sel(test_sel), .pulse_width_sel(pulse_width_sel), .main_count(main_count),
    .swallow_count(swallow_count), .prescale_sel(prescale_sel), .fast_timeout(fast_timeout),
    .detector_sign(detector_sign), .pump_current(pump_current), .fast_lock_active(fast_lock_active),
    .counter_load(counter_load), .pump_hiz_out(pump_hiz_out), .lock_detect_clear(lock_detect_clear),
    .dc_paths_off(dc_paths_off), .rf_debias(rf_debias), .ref_buffer_off(ref_buffer_off),
    .powered_down(powered_down), .observe_output(observe_output));

  host_serial_model i_host_serial_model (
    .mclk(mclk), .serial_clock(serial_clock), .serial_data(serial_data), .latch_strobe(latch_strobe));

  // ---------------------------------------------------------------
  // clock, timeout and pulse counting
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // one-cycle counter reset pulses are counted here, too short to poll
  always @(posedge mclk) begin
    cl_q <= counter_load;
    if (reset_n === 1'h1 && counter_load === 1'h1 && cl_q === 1'h0) n_rise <= n_rise + 1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic synth_pkg::word_type fnw(input logic [23:0] r, input logic pd2, fmode, fen, pd1, hold);
    return {r[23:22], pd2, r[20:11], fmode, fen, r[8:4], pd1, hold, `DEST_FUNC};
  endfunction : fnw

  function automatic logic fast_on(input logic [23:0] fn, input logic [23:0] fb);
    return fn[`FN_FEN] && fn[`FN_FMODE] == `FAST_MODE_ONE && fb[`FB_FAST_REQ];
  endfunction : fast_on

  task automatic wr(input synth_pkg::word_type x);
    i_host_serial_model.send_word(x);
    case (x[1:0])
      `DEST_REF: sh_ref = x;
      `DEST_FB:  sh_fb = x;
      default:   sh_fn = x;
    endcase
    repeat (10) @(posedge mclk);
    #1;
  endtask : wr

  task automatic check_fields();
    chk("ref_ratio", 24'(sh_ref[`REF_RATIO_HI:`REF_RATIO_LO]), 24'(ref_ratio));
    chk("lock_window", 24'(sh_ref[`REF_LDP]), 24'(lock_window_count_sel));
    chk("test_sel", 24'(sh_ref[`REF_TEST_HI:`REF_TEST_LO]), 24'(test_sel));
    chk("pulse_width", 24'(sh_ref[`REF_PW_HI:`REF_PW_LO]), 24'(pulse_width_sel));
    chk("main_count", 24'(sh_fb[`FB_MAIN_HI:`FB_MAIN_LO]), 24'(main_count));
    chk("swallow", 24'(sh_fb[`FB_SWAL_HI:`FB_SWAL_LO]), 24'(swallow_count));
    chk("prescale", 24'(sh_fn[`FN_PRE_HI:`FN_PRE_LO]), 24'(prescale_sel));
    chk("timeout", 24'(sh_fn[`FN_TMO_HI:`FN_TMO_LO]), 24'(fast_timeout));
    chk("sign", 24'(sh_fn[`FN_SIGN]), 24'(detector_sign));
    chk("observe", 24'(observe_sources[sh_fn[`FN_OBS_HI:`FN_OBS_LO]]), 24'(observe_output));
    chk("fast_active", 24'(fast_on(sh_fn, sh_fb)), 24'(fast_lock_active));
    chk("pump_current", 24'(fast_on(sh_fn, sh_fb) ? sh_fn[20:18] : sh_fn[17:15]), 24'(pump_current));
  endtask : check_fields

  task automatic check_pd(input logic e);
    chk("powered_down", 24'(e), 24'(powered_down));
    chk("dc_paths_off", 24'(e), 24'(dc_paths_off));
    chk("rf_debias", 24'(e), 24'(rf_debias));
    chk("ref_buffer_off", 24'(e), 24'(ref_buffer_off));
    chk("lock_clear", 24'(e), 24'(lock_detect_clear));
    chk("counter_load", 24'(e | sh_fn[`FN_HOLD]), 24'(counter_load));
    chk("pump_hiz", 24'(e | sh_fn[`FN_HOLD] | sh_fn[`FN_HIZ]), 24'(pump_hiz_out));
  endtask : check_pd

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_n = 1'h0;
    chip_enable = 1'h1;
    pump_event = 1'h0;
    observe_sources = 8'h00;
    {sh_ref, sh_fb, sh_fn} = '0;
    {n_mismatch, comparisons, n_rise, cycles} = '0;
    cl_q = 1'h0;
    seed = $urandom(23);
    settle(6);
    check_pd(1'h1);
    check_fields();
    reset_n = 1'h1;
    settle(8);
    check_pd(1'h0);
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 24'hfffffc : 24'($urandom);
      w[1:0] = `DEST_REF;
      wr(w);
      w = (i == 0) ? 24'hfffffd : 24'($urandom);
      w[1:0] = `DEST_FB;
      wr(w);
      check_fields();
    end
    // every observe select code, random sources
    for (int s = 0; s < 8; s++) begin
      observe_sources = 8'($urandom);
      w = fnw(24'($urandom), 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
      w[`FN_OBS_HI:`FN_OBS_LO] = 3'(s);
      wr(w);
      check_fields();
      check_pd(1'h0);
    end
    wr(fnw(24'($urandom), 1'h0, 1'h0, 1'h0, 1'h0, 1'h1));
    check_pd(1'h0);
    wr(fnw(24'($urandom), 1'h0, 1'h0, 1'h0, 1'h0, 1'h0));
    check_pd(1'h0);
    chip_enable = 1'h0;
    settle(6);
    check_pd(1'h1);
    w = 24'($urandom);
    w[1:0] = `DEST_REF;
    wr(w);
    check_fields();
    check_pd(1'h1);
    chip_enable = 1'h1;
    settle(6);
    check_pd(1'h0);
    wr(fnw(24'($urandom), 1'h0, 1'h0, 1'h0, 1'h1, 1'h0));
    check_pd(1'h1);
    wr(fnw(24'($urandom), 1'h0, 1'h0, 1'h0, 1'h0, 1'h0));
    check_pd(1'h0);
    wr(fnw(24'($urandom), 1'h1, 1'h0, 1'h0, 1'h1, 1'h0));
    check_pd(1'h0);
    pump_event = 1'h1;
    settle(10);
    pump_event = 1'h0;
    check_pd(1'h1);
    wr(fnw(24'($urandom), 1'h0, 1'h0, 1'h0, 1'h0, 1'h0));
    check_pd(1'h0);
    // fastlock mode one entered and left by the host, then mode two, then disabled
    wr(fnw(24'($urandom), 1'h0, 1'h0, 1'h1, 1'h0, 1'h0));
    for (int g = 1; g >= 0; g--) begin
      w = 24'($urandom);
      w[`FB_FAST_REQ] = 1'(g);
      w[1:0] = `DEST_FB;
      wr(w);
      check_fields();
    end
    wr(fnw(24'($urandom), 1'h0, 1'h1, 1'h1, 1'h0, 1'h0));
    wr(w | 24'h200000);
    check_fields();
    wr(fnw(24'($urandom), 1'h0, 1'h0, 1'h0, 1'h0, 1'h0));
    check_fields();
    // init pulses: one on init, one on first feedback write, none after
    n0 = n_rise;
    wr(fnw(24'($urandom), 1'h0, 1'h0, 1'h0, 1'h0, 1'h0) | 24'h000003);
    check_fields();
    chk("init_pulse", 24'h000001, 24'(n_rise - n0));
    for (int k = 0; k < 2; k++) begin
      w = 24'($urandom) & 24'hdffffc;
      wr(w | 24'h000001);
      chk("fb_pulse", 24'h000002, 24'(n_rise - n0));
    end
    check_pd(1'h0);
    summarize();
  end
endmodule : test_synth_control_latches
